// ==== hw/mba_arbiter.sv ====
// bus arbitration logic of one processor on a shared multiprocessor bus
`timescale 1ns/100ps
`default_nettype none

module mba_arbiter #(
  parameter int unsigned NUM_PROCS = mba_pkg::NUM_PROCS  // request lines on the bus
) (
  input  wire logic                         clk_sys_in,           // system clock, 40 MHz
  input  wire logic                         rst_n_in,             // synchronous reset, active low
  // identity straps, steady outside reset
  input  wire logic [mba_pkg::ID_W-1:0]     processor_identity_in,
  // bus request lines, one per processor; our own line is always driven, high or low
  input  wire logic [NUM_PROCS-1:0]         proc_bus_request_lines_n_in,
  output logic      [NUM_PROCS-1:0]         proc_bus_request_lines_n_out,
  output logic      [NUM_PROCS-1:0]         proc_bus_request_lines_oe_out,
  // host handshake
  input  wire logic                         host_request_n_in,
  input  wire logic                         backoff_request_n_in,
  input  wire logic                         host_grant_n_in,      // monitored while slave
  output logic                              host_grant_n_out,
  output logic                              host_grant_oe_out,
  // owner indicator, a strap during reset
  input  wire logic                         owner_indicator_in,
  output logic                              owner_indicator_out,
  output logic                              owner_indicator_oe_out,
  output logic                              strap_value_out,      // strap caught at reset release
  // priority access lines, open drain
  input  wire logic                         core_priority_line_n_in,
  output logic                              core_priority_line_oe_out,
  input  wire logic                         dma_priority_line_n_in,
  output logic                              dma_priority_line_oe_out,
  output logic                              priority_pullup_en_out,
  // lock indication
  output logic                              lock_indication_out,
  output logic                              lock_indication_oe_out,
  // requests from the processor's own external port
  input  wire logic                         core_access_in,       // core wants/uses external memory
  input  wire logic                         dma_high_access_in,   // high-priority dma wants the bus
  input  wire logic                         dma_normal_access_in, // normal dma wants the bus
  input  wire logic                         lock_request_in,      // keep the bus locked
  input  wire logic                         xact_pending_in,      // a transaction is outstanding
  input  wire logic [mba_pkg::ADDR_W-1:0]   xact_addr_in,         // its address
  // control to the external port
  output logic                              bus_drive_en_out,     // port may drive addr/data/strobes
  output logic                              xact_abort_out,       // abandon pending transaction
  output logic                              sdram_self_refresh_out,
  output logic                              dma_background_hold_out, // pause background dma
  output logic                              dma_normal_hold_out,  // pause normal-priority dma
  output logic                              host_space_select_out,// pending access is host space
  output logic                              slave_grant_seen_out  // grant observed while slave
);

  // refuse a line count that the identity width cannot index one-hot
  if (NUM_PROCS != (1 << mba_pkg::ID_W)) begin : g_bad_procs
    $error("NUM_PROCS must match identity width");
  end

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // one-hot decode of an identity to its request line
  function automatic logic [NUM_PROCS-1:0] id_onehot(input logic [mba_pkg::ID_W-1:0] id);
    logic [NUM_PROCS-1:0] v;
    v = '0;
    v[id] = 1'b1;
    return v;
  endfunction : id_onehot

  // true when the address lies in host memory space
  function automatic logic is_host_space(input logic [mba_pkg::ADDR_W-1:0] a);
    return a[mba_pkg::ADDR_W-1 -: mba_pkg::HOST_TOP_W] != mba_pkg::HOST_TOP_ZERO;
  endfunction : is_host_space

  //////////////////////////////////////////////////////////////////////////////
  // synchronise pin inputs

  logic [NUM_PROCS-1:0] req_s;       // request lines after two flops, low = asserted
  logic [4:0]           ctl_s;       // host req, backoff, grant, cpa, dpa
  logic [1:0]           strap_sync_q; // strap pin, two flops that reset never clears

  mba_sync #(.WIDTH(NUM_PROCS), .RST_VAL(1'b1)) u_sync_req (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (proc_bus_request_lines_n_in),
    .sync_out   (req_s)
  );

  mba_sync #(.WIDTH(5), .RST_VAL(1'b1)) u_sync_ctl (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({host_request_n_in, backoff_request_n_in, host_grant_n_in,
                  core_priority_line_n_in, dma_priority_line_n_in}),
    .sync_out   (ctl_s)
  );

  // the strap must be seen while reset is still low, so its two flops
  // are kept out of reset; a reset synchroniser would only show idle
  always_ff @(posedge clk_sys_in) begin
    strap_sync_q <= {strap_sync_q[0], owner_indicator_in};
  end

  logic host_req;          // host wants the bus
  logic backoff;           // host forces back-off
  logic grant_seen;        // grant level on the pin
  logic cpa_any;           // someone holds core priority
  logic dpa_any;           // someone holds dma priority
  logic strap_s;           // strap level during reset

  assign host_req   = !ctl_s[4];
  assign backoff    = !ctl_s[3];
  assign grant_seen = !ctl_s[2];
  assign cpa_any    = !ctl_s[1];
  assign dpa_any    = !ctl_s[0];
  assign strap_s    =  strap_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // identity, strap and own request line

  logic [mba_pkg::ID_W-1:0] id_q;     // identity caught while in reset
  logic                     strap_q;  // owner-indicator strap
  logic                     rst_d1_q; // reset seen last cycle, for release capture

  // identity follows the pins while reset is held, the strap until a cycle after; the
  // system keeps the straps steady afterwards, so we freeze them
  always_ff @(posedge clk_sys_in) begin
    rst_d1_q <= !rst_n_in;
    if (!rst_n_in) begin
      id_q <= processor_identity_in;
    end
    if (rst_d1_q) begin
      strap_q <= strap_s;
    end
  end

  assign strap_value_out = strap_q;

  logic [NUM_PROCS-1:0] own_line;    // one-hot of our request line
  logic [NUM_PROCS-1:0] others_req;  // active requests of the other processors
  logic                 higher_req;  // a processor ahead of us is requesting

  assign own_line   = id_onehot(id_q);
  assign others_req = ~req_s & ~own_line;
  // lower identity wins a tie; ours is only beaten by lower indices
  assign higher_req = |(others_req & (own_line - NUM_PROCS'(1)));

  //////////////////////////////////////////////////////////////////////////////
  // arbitration state machine

  mba_pkg::mba_state_t state_q;      // arbiter state
  mba_pkg::mba_state_t state_d;      // next state
  logic                want_bus;     // our side needs the bus
  logic                bus_busy;     // a processor ahead of us requests or host holds
  logic                abort_ok;     // back-off may abandon the pending access
  logic                refresh_q;    // sdram held in self-refresh

  assign want_bus = core_access_in | dma_high_access_in | dma_normal_access_in;
  assign bus_busy = grant_seen | higher_req;
  assign abort_ok = backoff & xact_pending_in & is_host_space(xact_addr_in);

  // next-state decision
  always_comb begin
    state_d = state_q;
    case (state_q)
      mba_pkg::MBA_IDLE: begin
        if (want_bus && !grant_seen) state_d = mba_pkg::MBA_REQ;
      end
      mba_pkg::MBA_REQ: begin
        if (!want_bus) state_d = mba_pkg::MBA_IDLE;
        else if (!bus_busy && !host_req) state_d = mba_pkg::MBA_OWN;
      end
      mba_pkg::MBA_OWN: begin
        // host request waits for the outstanding access
        if (abort_ok) state_d = mba_pkg::MBA_RELEASE;
        else if (host_req && !xact_pending_in) state_d = mba_pkg::MBA_RELEASE;
        else if (!xact_pending_in && !lock_request_in && !want_bus) state_d = mba_pkg::MBA_IDLE;
        else if (!xact_pending_in && !lock_request_in && higher_req) state_d = mba_pkg::MBA_IDLE;
      end
      mba_pkg::MBA_RELEASE: begin
        // a host request, with or without a back-off, waits for self-refresh
        if (host_req && refresh_q) state_d = mba_pkg::MBA_HOST;
        else if (!host_req) state_d = mba_pkg::MBA_IDLE;
      end
      mba_pkg::MBA_HOST: begin
        if (!host_req) state_d = mba_pkg::MBA_IDLE;
      end
      default: state_d = mba_pkg::MBA_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) state_q <= mba_pkg::MBA_IDLE;
    else           state_q <= state_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic owner_q;        // we own the bus
  logic grant_q;        // we assert the host grant
  logic grant_oe_q;     // we drive the grant pin
  logic req_q;          // our request line is low
  logic lock_q;         // bus locked by us
  logic abort_q;        // pending access abandoned
  logic hsel_q;         // pending access decodes host space
  logic cpa_q;          // our core holds core priority
  logic dpa_q;          // our high dma holds dma priority
  logic bg_hold_q;      // background dma paused
  logic nd_hold_q;      // normal dma paused
  logic pullup_q;       // priority pull-ups enabled

  // ownership, lock and request line
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      owner_q <= 1'b0;
      lock_q  <= 1'b0;
      req_q   <= 1'b0;
    end else begin
      owner_q <= (state_d == mba_pkg::MBA_OWN);
      lock_q  <= (state_d == mba_pkg::MBA_OWN) && lock_request_in;
      req_q   <= (state_d == mba_pkg::MBA_REQ) || (state_d == mba_pkg::MBA_OWN);
    end
  end

  // host grant: driven only by the owner, held until request drops
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      grant_q    <= 1'b0;
      grant_oe_q <= 1'b0;
    end else begin
      grant_q    <= (state_d == mba_pkg::MBA_HOST);
      // pin stays driven through the handover so the grant is never floated
      grant_oe_q <= (state_d == mba_pkg::MBA_OWN) || (state_d == mba_pkg::MBA_RELEASE)
                    || (state_d == mba_pkg::MBA_HOST);
    end
  end

  // sdram self-refresh and transaction abort
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      refresh_q <= 1'b0;
      abort_q   <= 1'b0;
      hsel_q    <= 1'b0;
    end else begin
      refresh_q <= (state_d == mba_pkg::MBA_RELEASE && host_req)
                   || (state_d == mba_pkg::MBA_HOST);
      abort_q   <= (state_q == mba_pkg::MBA_OWN) && abort_ok;
      hsel_q    <= xact_pending_in && is_host_space(xact_addr_in);
    end
  end

  // priority access lines and the dma holds they cause on the owner
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cpa_q     <= 1'b0;
      dpa_q     <= 1'b0;
      bg_hold_q <= 1'b0;
      nd_hold_q <= 1'b0;
      pullup_q  <= 1'b0;
    end else begin
      cpa_q     <= core_access_in;
      dpa_q     <= dma_high_access_in;
      // our own assertion also pulls the wire low, so exclude it
      bg_hold_q <= owner_q && cpa_any && !cpa_q;
      nd_hold_q <= owner_q && dpa_any && !dpa_q;
      pullup_q  <= (id_q == '0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drive

  // request line: drive only our own bit, low while requesting
  assign proc_bus_request_lines_oe_out = own_line;
  assign proc_bus_request_lines_n_out  = ~(own_line & {NUM_PROCS{req_q}});

  assign host_grant_n_out      = !grant_q;
  assign host_grant_oe_out     = grant_oe_q;
  assign slave_grant_seen_out  = grant_seen && !grant_oe_q;

  // owner pin is an input strap in reset, an output after
  assign owner_indicator_out    = owner_q;
  assign owner_indicator_oe_out = rst_n_in && !rst_d1_q;

  // open drain: enable pulls low
  assign core_priority_line_oe_out = cpa_q;
  assign dma_priority_line_oe_out  = dpa_q;
  assign priority_pullup_en_out    = pullup_q;

  assign lock_indication_out    = lock_q;
  assign lock_indication_oe_out = owner_q;

  // address, data, selects, strobes and sdram pins float once released
  assign bus_drive_en_out        = owner_q;
  assign xact_abort_out          = abort_q;
  assign sdram_self_refresh_out  = refresh_q;
  assign dma_background_hold_out = bg_hold_q;
  assign dma_normal_hold_out     = nd_hold_q;
  assign host_space_select_out   = hsel_q;

endmodule : mba_arbiter

`default_nettype wire

// ==== hw/mba_pkg.sv ====
// package of constants and types for the multiprocessor bus arbitration block
//
// Overview of operation
// - drive own request line, watch all others
// - identity selects request line by binary index
// - arbitration order derives from identity value
// - owner drives indicator; pin strapped at reset
// - back-off aborts only host-space pending transaction
// - lock indication while owner holds lock
// - finish transaction, release bus, then grant host
// - release floats address, data, selects, strobes, sdram
// - handing to host puts sdram into self-refresh
// - grant held until host drops request
// - only owner drives grant; slaves monitor it
// - core priority line asserted during core access
// - slave core priority pre-empts owner background dma
// - dma priority line asserted during high dma
// - slave dma priority pre-empts owner normal dma
// - priority line pull-ups only for identity zero
// - host space: top four address bits nonzero
package mba_pkg;

  // arbitration geometry
  localparam int unsigned NUM_PROCS  = 8;            // processors on the shared bus
  localparam int unsigned ID_W       = 3;            // identity width
  localparam int unsigned ADDR_W     = 32;           // address bus width
  localparam int unsigned DATA_W     = 64;           // data bus width
  localparam int unsigned HOST_TOP_W = 4;            // address bits that decode host space
  localparam logic [3:0]  HOST_TOP_ZERO = 4'h0;      // top nibble code outside host space

  // reset values of the active-low lines, all idle high
  localparam logic [7:0]  REQ_IDLE   = 8'hFF;        // no request lines pulled low
  localparam logic        LINE_IDLE  = 1'b1;         // idle level of an active-low line

  // arbiter states, gray along idle -> request -> own -> release -> host
  typedef enum logic [2:0] {
    MBA_IDLE    = 3'b000,   // slave, not requesting
    MBA_REQ     = 3'b001,   // requesting, waiting for ownership
    MBA_OWN     = 3'b011,   // owner of the bus
    MBA_RELEASE = 3'b010,   // owner finishing, sdram to self-refresh
    MBA_HOST    = 3'b110    // bus handed to host, grant held
  } mba_state_t;

endpackage : mba_pkg

// ==== hw/mba_sync.sv ====
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none

module mba_sync #(
  parameter int unsigned WIDTH = 1,                 // bits to synchronise
  parameter logic        RST_VAL = 1'b1             // idle value for every bit
) (
  input  wire logic             clk_sys_in,         // system clock
  input  wire logic             rst_n_in,           // synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_in,           // raw pin levels
  output logic      [WIDTH-1:0] sync_out            // levels safe for logic
);

  logic [WIDTH-1:0] meta_q;                         // first stage, read by second only
  logic [WIDTH-1:0] sync_q;                         // second stage

  // two stages, first one feeds nothing but the second
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_q <= {WIDTH{RST_VAL}};
      sync_q <= {WIDTH{RST_VAL}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : mba_sync

`default_nettype wire

// ==== tb/mba_arbiter_assertions.sv ====
// checker of arbitration timing at the arbiter ports
`timescale 1ns/100ps
`default_nettype none

module mba_arbiter_checker #(
  parameter int unsigned NUM_PROCS = mba_pkg::NUM_PROCS  // request lines
) (
  input wire logic                       clk_sys_in,
  input wire logic                       rst_n_in,
  input wire logic [mba_pkg::ID_W-1:0]   processor_identity_in,
  input wire logic [NUM_PROCS-1:0]       proc_bus_request_lines_n_out,
  input wire logic [NUM_PROCS-1:0]       proc_bus_request_lines_oe_out,
  input wire logic                       host_request_n_in,
  input wire logic                       host_grant_n_out,
  input wire logic                       host_grant_oe_out,
  input wire logic                       owner_indicator_out,
  input wire logic                       core_priority_line_oe_out,
  input wire logic                       dma_priority_line_oe_out,
  input wire logic                       priority_pullup_en_out,
  input wire logic                       lock_indication_out,
  input wire logic                       lock_indication_oe_out,
  input wire logic                       core_access_in,
  input wire logic                       dma_high_access_in,
  input wire logic                       xact_pending_in,
  input wire logic [mba_pkg::ADDR_W-1:0] xact_addr_in,
  input wire logic                       bus_drive_en_out,
  input wire logic                       xact_abort_out,
  input wire logic                       sdram_self_refresh_out,
  input wire logic                       host_space_select_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  // host handover steps
  sequence s_host_hold;
    !host_grant_n_out && !host_request_n_in;
  endsequence
  sequence s_grant_back;
    $past(rst_n_in) && $rose(host_grant_n_out);
  endsequence
  ////////////////////////////////////////////////////////////
  a_own_line_only: assert property ($past(rst_n_in) |->
    proc_bus_request_lines_oe_out == (NUM_PROCS'(1) << processor_identity_in)) else $error("wrong request line");
  a_other_lines_idle: assert property (&(proc_bus_request_lines_n_out | proc_bus_request_lines_oe_out))
    else $error("undriven request bit low");
  a_drive_needs_owner: assert property (bus_drive_en_out |-> owner_indicator_out)
    else $error("bus driven by non owner");
  a_lock_needs_owner: assert property (lock_indication_out |-> lock_indication_oe_out && owner_indicator_out)
    else $error("lock without ownership");
  a_grant_by_owner: assert property (!host_grant_n_out |-> host_grant_oe_out && !bus_drive_en_out)
    else $error("grant while bus driven");
  a_grant_after_release: assert property ($past(rst_n_in) && $fell(host_grant_n_out) |->
    $past(sdram_self_refresh_out) && $past(!bus_drive_en_out)) else $error("grant before release");
  a_grant_holds: assert property (s_host_hold |=> !host_grant_n_out) else $error("grant dropped early");
  a_grant_release: assert property (s_grant_back |-> $past(host_request_n_in, 2))
    else $error("grant dropped with host waiting");
  a_host_space: assert property ($past(rst_n_in) |-> host_space_select_out ==
    $past(xact_pending_in && xact_addr_in[31:28] != 4'h0)) else $error("host space decode");
  a_abort_host_only: assert property ($past(rst_n_in) && xact_abort_out |->
    $past(xact_pending_in && xact_addr_in[31:28] != 4'h0)) else $error("abort outside host space");
  a_pullup_id_zero: assert property ($past(rst_n_in) |-> priority_pullup_en_out == (processor_identity_in == 3'h0))
    else $error("pull-up enable");
  a_core_line: assert property ($past(rst_n_in) |-> core_priority_line_oe_out == $past(core_access_in))
    else $error("core line timing");
  a_dma_line: assert property ($past(rst_n_in) |-> dma_priority_line_oe_out == $past(dma_high_access_in))
    else $error("dma line timing");
endmodule : mba_arbiter_checker

bind mba_arbiter mba_arbiter_checker #(.NUM_PROCS(NUM_PROCS)) u_chk (.*);

`default_nettype wire

// ==== tb/mba_arbiter_bench.sv ====
// self-checking bench for the bus arbitration block
`timescale 1ns/100ps
`default_nettype none

module mba_arbiter_bench;
  `define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("mismatch at %0t: %b not %b", $time, a, e); end end
  logic        clk_sys_in = 1'b0;  // 40 MHz system clock
  logic        rst_n_in   = 1'b0;  // reset, active low
  logic [7:0]  peer_want  = 8'h00; // peers asking
  logic        host_want  = 1'b0;  // host asking
  logic        backoff_request_want  = 1'b0;  // host back-off
  logic        cpa_want   = 1'b0;  // peer core access
  logic        dpa_want   = 1'b0;  // peer high dma
  logic        core_acc   = 1'b0;  // own core access
  logic        dmah_acc   = 1'b0;  // own high dma
  logic        dman_acc   = 1'b0;  // own normal dma
  logic        lock_req   = 1'b0;  // own lock
  logic        pend       = 1'b0;  // own pending transfer
  logic [31:0] addr       = 32'h0; // its address
  wire logic [7:0] req_n, req_n_o, req_oe;
  wire logic   host_n, backoff_request_n, grant_n, grant_n_o, grant_oe, own_pin, own_o, own_oe;
  wire logic   cpa_n, cpa_oe, dpa_n, dpa_oe;
  wire logic [10:0] obs;           // watched outputs by index
  int          errors = 0;         // mismatches
  int          checks = 0;         // comparisons
  int          i;                  // loop index
  logic [4:0]  exp_q[$];           // notes of {index, value}
  logic [4:0]  nt;                 // note under test
  event        probe;              // a result is ready

  always #12.5 clk_sys_in = ~clk_sys_in;

  ////////////////////////////////////////////////////////////
  // identity three, steady for the whole run: peer one outranks us, no pull-up
  mba_arbiter DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .processor_identity_in(3'h3),
    .proc_bus_request_lines_n_in(req_n), .proc_bus_request_lines_n_out(req_n_o),
    .proc_bus_request_lines_oe_out(req_oe), .host_request_n_in(host_n), .backoff_request_n_in(backoff_request_n),
    .host_grant_n_in(grant_n), .host_grant_n_out(grant_n_o), .host_grant_oe_out(grant_oe),
    .owner_indicator_in(own_pin), .owner_indicator_out(own_o), .owner_indicator_oe_out(own_oe),
    .strap_value_out(obs[10]), .core_priority_line_n_in(cpa_n), .core_priority_line_oe_out(cpa_oe),
    .dma_priority_line_n_in(dpa_n), .dma_priority_line_oe_out(dpa_oe), .priority_pullup_en_out(obs[9]),
    .lock_indication_out(obs[8]), .lock_indication_oe_out(), .core_access_in(core_acc),
    .dma_high_access_in(dmah_acc), .dma_normal_access_in(dman_acc), .lock_request_in(lock_req),
    .xact_pending_in(pend), .xact_addr_in(addr), .bus_drive_en_out(obs[1]), .xact_abort_out(obs[4]),
    .sdram_self_refresh_out(obs[3]), .dma_background_hold_out(obs[6]), .dma_normal_hold_out(obs[7]),
    .host_space_select_out(obs[5]), .slave_grant_seen_out());
  assign obs[0] = own_o;
  assign obs[2] = grant_n_o;

  mba_peer_model u_far (.peer_want_in(peer_want), .host_want_in(host_want), .backoff_request_want_in(backoff_request_want),
    .cpa_want_in(cpa_want), .dpa_want_in(dpa_want), .dut_req_n_in(req_n_o), .dut_req_oe_in(req_oe),
    .dut_grant_n_in(grant_n_o), .dut_grant_oe_in(grant_oe), .dut_own_in(own_o), .dut_own_oe_in(own_oe),
    .dut_cpa_oe_in(cpa_oe), .dut_dpa_oe_in(dpa_oe), .req_n_out(req_n), .host_n_out(host_n),
    .backoff_request_n_out(backoff_request_n), .grant_n_out(grant_n), .own_out(own_pin), .cpa_n_out(cpa_n), .dpa_n_out(dpa_n));

  ////////////////////////////////////////////////////////////
  // monitor: drains notes oldest first when told
  always @(probe) begin
    while (exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      `CHK(obs[nt[4:1]], nt[0])
    end
  end

  task automatic note(input int s, input logic e);
    exp_q.push_back({s[3:0], e});
    -> probe;
  endtask : note

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc

  // bounded wait; running out ends the run
  task automatic wait_for(input int s, input logic v);
    int n;
    n = 0;
    while (obs[s] !== v && n < 60) begin
      cyc(1);
      n++;
    end
    if (obs[s] !== v) begin
      errors++;
      $display("mismatch at %0t: wait on output %0d ran out", $time, s);
      complete_run();
    end
  endtask : wait_for

  task complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////
  // main sequence, inputs change on falling edges only
  initial begin
    void'($urandom(55));
    cyc(16);
    rst_n_in = 1'b1;
    cyc(3);
    note(9, 1'b0);
    note(2, 1'b1);
    note(10, 1'b0);
    $display("reset test done");
    peer_want = 8'h02;                     // lower identity holds its line
    core_acc  = 1'b1;
    cyc(10);
    note(0, 1'b0);
    peer_want = 8'h00;
    wait_for(0, 1'b1);
    note(1, 1'b1);
    lock_req = 1'b1;
    cyc(2);
    note(8, 1'b1);
    lock_req = 1'b0;
    $display("ownership test done");
    dman_acc = 1'b1;                       // keep wanting through normal dma
    core_acc = 1'b0;
    cpa_want = 1'b1;
    cyc(5);
    note(6, 1'b1);
    cpa_want = 1'b0;
    dpa_want = 1'b1;
    cyc(5);
    note(7, 1'b1);
    dpa_want = 1'b0;
    dmah_acc = 1'b1;
    cyc(3);
    dmah_acc = 1'b0;
    $display("priority test done");
    pend = 1'b1;
    for (i = 0; i < 8; i++) begin
      addr = $urandom();
      if (i < 2) addr[31:28] = 4'h0;
      cyc(2);
      note(5, addr[31:28] != 4'h0);
    end
    addr = 32'h0800_0000;                  // local space: back-off refused
    cyc(3);
    backoff_request_want = 1'b1;
    cyc(5);
    note(4, 1'b0);
    backoff_request_want = 1'b0;
    addr = 32'hA000_0004;
    cyc(3);
    backoff_request_want = 1'b1;
    wait_for(4, 1'b1);
    note(4, 1'b1);
    backoff_request_want = 1'b0;
    cyc(3);
    wait_for(0, 1'b1);
    $display("back-off test done");
    host_want = 1'b1;                      // pending transfer first
    cyc(8);
    note(2, 1'b1);
    pend = 1'b0;
    wait_for(2, 1'b0);
    note(3, 1'b1);
    note(1, 1'b0);
    cyc(10);
    note(2, 1'b0);
    host_want = 1'b0;
    wait_for(2, 1'b1);
    note(3, 1'b0);
    $display("host test done");
    cyc(2);
    complete_run();
  end
  `undef CHK
endmodule : mba_arbiter_bench

`default_nettype wire

// ==== tb/mba_peer_model.sv ====
// far side of the arbiter: peers, host and the wired line pulls
`timescale 1ns/100ps
`default_nettype none

module mba_peer_model (
  input  wire logic [7:0] peer_want_in,   // peers asking for the bus
  input  wire logic       host_want_in,   // host wants the bus
  input  wire logic       backoff_request_want_in,   // host forces a back-off
  input  wire logic       cpa_want_in,    // a peer core uses memory
  input  wire logic       dpa_want_in,    // a peer high dma uses memory
  input  wire logic [7:0] dut_req_n_in,   // arbiter request drive
  input  wire logic [7:0] dut_req_oe_in,  // arbiter request enables
  input  wire logic       dut_grant_n_in, // arbiter grant drive
  input  wire logic       dut_grant_oe_in,
  input  wire logic       dut_own_in,     // owner indicator drive
  input  wire logic       dut_own_oe_in,
  input  wire logic       dut_cpa_oe_in,  // arbiter pulls core line
  input  wire logic       dut_dpa_oe_in,  // arbiter pulls dma line
  output logic      [7:0] req_n_out,      // resolved request lines
  output logic            host_n_out,     // host request pin
  output logic            backoff_request_n_out,     // back-off pin
  output logic            grant_n_out,    // resolved grant pin
  output logic            own_out,        // resolved indicator pin
  output logic            cpa_n_out,      // resolved core line
  output logic            dpa_n_out       // resolved dma line
);
  ////////////////////////////////////////////////////////////
  // undriven lines fall to their pulls, never hold the last value
  assign req_n_out   = (dut_req_oe_in & dut_req_n_in) | (~dut_req_oe_in & ~peer_want_in);
  assign host_n_out  = !host_want_in;   // held for as long as wanted
  assign backoff_request_n_out  = !backoff_request_want_in;
  assign grant_n_out = dut_grant_oe_in ? dut_grant_n_in : 1'b1;   // pull-up when nobody drives
  assign own_out     = dut_own_oe_in ? dut_own_in : 1'b0;        // pull-down strap in reset
  assign cpa_n_out   = !(dut_cpa_oe_in | cpa_want_in);            // open drain wired and
  assign dpa_n_out   = !(dut_dpa_oe_in | dpa_want_in);
endmodule : mba_peer_model

`default_nettype wire
